// ===== shared/sdc_pkg.sv
// Constants, field layouts and carrier types of the SDRAM address mux controller.
// Assumes a single 100 MHz core clock and a direct CPU register port.
package sdc_pkg;

    // ----------------------------------------------------------------
    // Clock and refresh timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int REFRESH_PERIOD_NS = 7800;
    // Longest time, so round down
    localparam int REFRESH_CYCLES    = REFRESH_PERIOD_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Register indices on the direct CPU port
    // ----------------------------------------------------------------
    localparam logic [1:0] REG_BANK_BASE   = 2'h0;
    localparam logic [1:0] REG_BANK_OPTION = 2'h1;
    localparam logic [1:0] REG_MODE_TIMING = 2'h2;
    localparam logic [1:0] REG_STATUS      = 2'h3;

    localparam logic [31:0] BANK_BASE_RST   = 32'h0000_0000;
    localparam logic [31:0] BANK_OPTION_RST = 32'h0000_0000;
    localparam logic [31:0] MODE_TIMING_RST = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Field low bits (field bit 0 is the word LSB)
    // ----------------------------------------------------------------
    localparam int BB_BASE_LO   = 15;   // 17 bits
    localparam int BB_PORT_LO   = 11;   // 2 bits
    localparam int BB_ECC_LO    = 9;    // 2 bits
    localparam int BB_WPROT     = 8;
    localparam int BB_MSEL_LO   = 5;    // 3 bits
    localparam int BB_EXTCTL    = 4;
    localparam int BB_ATOM_LO   = 2;    // 2 bits
    localparam int BB_PIPE      = 1;
    localparam int BB_VALID     = 0;

    localparam int BO_MASK_LO   = 15;   // 12 + 5 mask bits
    localparam int BO_BANKS_LO  = 13;   // 2 bits
    localparam int BO_ROWPOS_LO = 10;   // 3 bits
    localparam int BO_ROWCNT_LO = 6;    // 3 bits

    localparam int MD_REFEN     = 30;
    localparam int MD_OPSEL_LO  = 27;   // 3 bits
    localparam int MD_MUX_LO    = 24;   // 3 bits
    localparam int MD_BSEL_LO   = 21;   // 3 bits
    localparam int MD_A10_LO    = 18;   // 3 bits
    localparam int MD_REFREC_LO = 15;   // 3 bits
    localparam int MD_PRE_LO    = 12;   // 3 bits
    localparam int MD_ACT_LO    = 9;    // 3 bits
    localparam int MD_BURST     = 8;
    localparam int MD_LDO_LO    = 6;    // 2 bits
    localparam int MD_WREC_LO   = 4;    // 2 bits
    localparam int MD_CAS_LO    = 0;    // 2 bits

    // ----------------------------------------------------------------
    // Address mux encodings
    // ----------------------------------------------------------------
    localparam logic [5:0] ROW_START_BASE = 6'h03;
    localparam logic [5:0] ROW_LINES_BASE = 6'h09;
    localparam logic [5:0] MUX_SHIFT_BASE = 6'h08;
    localparam logic [5:0] AP_LINE_BASE   = 6'h0F;
    localparam logic [5:0] BANK_SEL_BASE  = 6'h05;
    localparam logic [4:0] BURST_SHORT    = 5'h04;
    localparam logic [4:0] BURST_LONG     = 5'h08;

    // ----------------------------------------------------------------
    // Memory commands as {csN, rasN, casN, weN}
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_REF   = 4'h1;

    typedef enum logic [2:0] {
        SDC_IDLE,
        SDC_ACT_WAIT,
        SDC_DATA_WAIT,
        SDC_PRE_WAIT,
        SDC_REF_WAIT
    } sdc_state_e;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [2:0]  bankSel;
        logic [31:0] addr;
    } sdc_mem_s;

endpackage

// ===== rtl/sdc_down_counter.sv
// Loadable down counter used for command spacing and the refresh period.
// Assumes load values of at least one; expired is a level while count is zero.
`timescale 1ns/100ps
module sdc_down_counter
    import sdc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    // Status
    output logic                  expired
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (WIDTH < 2 || WIDTH > 24) begin : gWidthCheck
        $error("sdc_down_counter: WIDTH out of range");
    end

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } sdc_cnt_s;

    sdc_cnt_s cnt_reg;
    sdc_cnt_s cnt_next;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next.count = loadValue;
        end else if (cnt_reg.count != '0) begin
            cnt_next.count = cnt_reg.count - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_reg.count <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Pure register decode, so a load fed from expired forms no loop
    assign expired = (cnt_reg.count == '0);

endmodule

// ===== rtl/sdc_controller.sv
// SDRAM address mux controller: registers, bank decode, address multiplexing,
// command sequencing and periodic refresh. Assumes requests synchronous to core_clk.
`timescale 1ns/100ps
module sdc_controller
    import sdc_pkg::*;
#(
    parameter int REFRESH_COUNT = REFRESH_CYCLES,
    parameter int REF_WIDTH     = 16
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Direct CPU register port
    input  wire logic [1:0]  regSel,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [31:0] regWrData,
    output logic      [31:0] regRdData,
    // Memory access requests
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic [31:0] reqAddr,
    output logic             reqReady,
    output logic             reqError,
    output logic             reqDone,
    // SDRAM pins
    output sdc_mem_s         memPins
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (REFRESH_COUNT < 2 || REFRESH_COUNT >= (1 << REF_WIDTH)) begin : gRefCheck
        $error("sdc_controller: REFRESH_COUNT does not fit REF_WIDTH");
    end

    typedef struct packed {
        logic [31:0] bankBase;
        logic [31:0] bankOption;
        logic [31:0] modeTiming;
        logic [31:0] rdData;
        sdc_state_e  state;
        logic        refreshPending;
        sdc_mem_s    mem;
        logic        done;
        logic        error;
        logic [31:0] addr;
        logic        isWrite;
        logic        resting;
    } sdc_core_s;

    sdc_core_s core_reg;
    sdc_core_s core_next;

    // Timer hookups
    logic                 seqLoad;
    logic [4:0]           seqValue;
    logic                 seqExpired;
    logic                 refExpired;

    // Decoded configuration
    logic [5:0]  rowStart;
    logic [5:0]  rowLines;
    logic [5:0]  rowEnd;
    logic [5:0]  muxShift;
    logic [5:0]  bankBits;
    logic [5:0]  apLine;
    logic [5:0]  bankSelEnd;
    logic [31:0] actMask;
    logic [31:0] bankMask;
    logic [31:0] colMask;
    logic [31:0] shiftedAddr;
    logic [31:0] bankSelWide;
    logic [4:0]  burstBeats;
    logic        addrHit;

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    sdc_down_counter #(
        .WIDTH     (5)
    ) u_seq_timer (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .load      (seqLoad),
        .loadValue (seqValue),
        .expired   (seqExpired)
    );

    // Free running; reloading on expiry gives one pulse per period
    sdc_down_counter #(
        .WIDTH     (REF_WIDTH)
    ) u_ref_timer (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .load      (refExpired),
        .loadValue (REF_WIDTH'(REFRESH_COUNT - 1)),
        .expired   (refExpired)
    );

    // ----------------------------------------------------------------
    // Address decode and multiplexing
    // ----------------------------------------------------------------
    always_comb begin
        rowStart    = ROW_START_BASE + {3'h0, core_reg.bankOption[BO_ROWPOS_LO +: 3]};
        rowLines    = ROW_LINES_BASE + {3'h0, core_reg.bankOption[BO_ROWCNT_LO +: 3]};
        rowEnd      = rowStart + rowLines - 6'h01;
        muxShift    = MUX_SHIFT_BASE + {3'h0, core_reg.modeTiming[MD_MUX_LO +: 3]};
        bankBits    = {4'h0, core_reg.bankOption[BO_BANKS_LO +: 2]} + 6'h01;
        apLine      = AP_LINE_BASE + {3'h0, core_reg.modeTiming[MD_A10_LO +: 3]};
        bankSelEnd  = BANK_SEL_BASE + {3'h0, core_reg.modeTiming[MD_BSEL_LO +: 3]}
                      + bankBits - 6'h01;
        // Bank and row land muxShift lines further down the bus
        shiftedAddr = core_reg.addr >> muxShift;
        actMask     = ((32'h1 << (rowLines + bankBits)) - 32'h1)
                      << (6'd31 - rowEnd - muxShift);
        bankMask    = ((32'h1 << bankBits) - 32'h1)
                      << (6'd32 - rowStart - muxShift);
        colMask     = ((32'h1 << (6'd29 - rowEnd)) - 32'h1) << 2;
        bankSelWide = (core_reg.addr >> (6'd31 - bankSelEnd))
                      & ((32'h1 << bankBits) - 32'h1);
        burstBeats  = core_reg.modeTiming[MD_BURST] ? BURST_LONG : BURST_SHORT;
        // Base compare under the 17-bit mask, valid bit gates the bank
        addrHit     = core_reg.bankBase[BB_VALID]
                      && (((reqAddr[31:15] ^ core_reg.bankBase[BB_BASE_LO +: 17])
                           & core_reg.bankOption[BO_MASK_LO +: 17]) == 17'h0);
    end

    // ----------------------------------------------------------------
    // Registers and command sequencer
    // ----------------------------------------------------------------
    always_comb begin
        core_next          = core_reg;
        core_next.mem.cmd  = CMD_NOP;
        core_next.done     = 1'b0;
        core_next.error    = 1'b0;
        seqLoad            = 1'b0;
        seqValue           = 5'h01;
        reqReady           = 1'b0;

        // Direct register access, no indirection
        if (regWrEn) begin
            case (regSel)
                REG_BANK_BASE:   core_next.bankBase   = regWrData;
                REG_BANK_OPTION: core_next.bankOption = regWrData;
                REG_MODE_TIMING: core_next.modeTiming = regWrData;
                default: ;
            endcase
        end
        if (regRdEn) begin
            case (regSel)
                REG_BANK_BASE:   core_next.rdData = core_reg.bankBase;
                REG_BANK_OPTION: core_next.rdData = core_reg.bankOption;
                REG_MODE_TIMING: core_next.rdData = core_reg.modeTiming;
                REG_STATUS:      core_next.rdData = {27'h0, core_reg.state,
                                                     core_reg.refreshPending,
                                                     core_reg.state != SDC_IDLE};
                default:         core_next.rdData = 32'h0;
            endcase
        end

        // Tick sets pending; set wins over the clear below
        if (refExpired && core_reg.modeTiming[MD_REFEN]) begin
            core_next.refreshPending = 1'b1;
        end

        case (core_reg.state)
            SDC_IDLE: begin
                if (core_reg.refreshPending && core_reg.modeTiming[MD_REFEN]) begin
                    core_next.mem.cmd = CMD_REF;
                    core_next.refreshPending = refExpired;
                    seqLoad  = 1'b1;
                    seqValue = {2'h0, core_reg.modeTiming[MD_REFREC_LO +: 3]} + 5'h01;
                    core_next.state = SDC_REF_WAIT;
                end else if (reqValid) begin
                    reqReady = 1'b1;
                    if (!addrHit || (reqWrite && core_reg.bankBase[BB_WPROT])) begin
                        // Miss or protected write: refused in one cycle
                        core_next.error = 1'b1;
                    end else begin
                        core_next.addr    = reqAddr;
                        core_next.isWrite = reqWrite;
                        core_next.state   = SDC_ACT_WAIT;
                    end
                end
            end
            SDC_ACT_WAIT: begin
                // First cycle here drives activate with the captured address
                if (core_reg.mem.cmd != CMD_ACT && seqExpired) begin
                    core_next.mem.cmd     = CMD_ACT;
                    core_next.mem.addr    = shiftedAddr & actMask;
                    core_next.mem.bankSel = bankSelWide[2:0];
                    seqLoad  = 1'b1;
                    seqValue = {2'h0, core_reg.modeTiming[MD_ACT_LO +: 3]} + 5'h01;
                end else if (core_reg.mem.cmd != CMD_ACT && !seqExpired) begin
                    core_next.mem.cmd = CMD_NOP;
                end else begin
                    core_next.state = SDC_DATA_WAIT;
                end
            end
            SDC_DATA_WAIT: begin
                if (core_reg.mem.cmd != CMD_READ && core_reg.mem.cmd != CMD_WRITE
                    && seqExpired) begin
                    core_next.mem.cmd  = core_reg.isWrite ? CMD_WRITE : CMD_READ;
                    // Column, same bank, auto precharge line high
                    core_next.mem.addr = (core_reg.addr & colMask)
                                         | (shiftedAddr & bankMask)
                                         | (32'h1 << (6'd31 - apLine));
                    seqLoad  = 1'b1;
                    seqValue = core_reg.isWrite
                        ? burstBeats + {3'h0, core_reg.modeTiming[MD_WREC_LO +: 2]} + 5'h01
                        : burstBeats + {3'h0, core_reg.modeTiming[MD_CAS_LO +: 2]};
                end else if (core_reg.mem.cmd == CMD_READ
                             || core_reg.mem.cmd == CMD_WRITE) begin
                    core_next.state = SDC_PRE_WAIT;
                end
            end
            SDC_PRE_WAIT: begin
                // Rest flag, not the one-cycle done pulse, marks the second wait
                if (seqExpired && !core_reg.resting) begin
                    // Auto precharge runs, then the bank needs its rest time
                    core_next.done    = 1'b1;
                    core_next.resting = 1'b1;
                    seqLoad  = 1'b1;
                    seqValue = {3'h0, core_reg.modeTiming[MD_LDO_LO +: 2]}
                               + {2'h0, core_reg.modeTiming[MD_PRE_LO +: 3]} + 5'h01;
                end else if (seqExpired) begin
                    core_next.resting = 1'b0;
                    core_next.state   = SDC_IDLE;
                end
            end
            SDC_REF_WAIT: begin
                // No activate until refresh recovery has run out
                if (seqExpired) begin
                    core_next.state = SDC_IDLE;
                end
            end
            default: begin
                core_next.state = SDC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            core_reg.bankBase       <= BANK_BASE_RST;
            core_reg.bankOption     <= BANK_OPTION_RST;
            core_reg.modeTiming     <= MODE_TIMING_RST;
            core_reg.rdData         <= 32'h0000_0000;
            core_reg.state          <= SDC_IDLE;
            core_reg.refreshPending <= 1'b0;
            core_reg.mem.cmd        <= CMD_NOP;
            core_reg.mem.bankSel    <= 3'h0;
            core_reg.mem.addr       <= 32'h0000_0000;
            core_reg.done           <= 1'b0;
            core_reg.error          <= 1'b0;
            core_reg.addr           <= 32'h0000_0000;
            core_reg.isWrite        <= 1'b0;
            core_reg.resting        <= 1'b0;
        end else begin
            core_reg <= core_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign regRdData = core_reg.rdData;
    assign reqError  = core_reg.error;
    assign reqDone   = core_reg.done;
    assign memPins   = core_reg.mem;

endmodule

// ===== verification/sdc_controller_properties.sv
// Port checks of the SDRAM controller, bound into every sdc_controller.
// Mapping checks apply once the example geometry is programmed.
`timescale 1ns/100ps
module sdc_controller_properties
    import sdc_pkg::*;
#(
    parameter int REFRESH_COUNT = REFRESH_CYCLES,
    parameter int REF_WIDTH     = 16
) (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Register port
    input wire logic [1:0]  regSel,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [31:0] regWrData,
    input wire logic [31:0] regRdData,
    // Access port
    input wire logic        reqValid,
    input wire logic        reqWrite,
    input wire logic [31:0] reqAddr,
    input wire logic        reqReady,
    input wire logic        reqError,
    input wire logic        reqDone,
    // Memory pins
    input wire sdc_mem_s    memPins
);
    logic [31:0] bb_reg, bo_reg, md_reg, lat_reg, ma;
    logic [15:0] actAge_reg, refAge_reg, refGap_reg;
    logic [3:0]  cmd;
    logic        taken, miss, ex, isRw;

    assign cmd = memPins.cmd;
    assign ma = memPins.addr;
    assign taken = reqValid && reqReady;
    assign isRw = cmd == CMD_READ || cmd == CMD_WRITE;
    assign ex = bo_reg[14:6] == 9'h0E3 && md_reg[26:18] == 9'h054;
    assign miss = !bb_reg[BB_VALID] || (reqWrite && bb_reg[BB_WPROT])
        || ((reqAddr[31:15] ^ bb_reg[31:15]) & bo_reg[31:15]) != 17'h0;

    // Ages saturate so long idle spells never wrap into a false gap
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bb_reg <= BANK_BASE_RST;
            bo_reg <= BANK_OPTION_RST;
            md_reg <= MODE_TIMING_RST;
            lat_reg <= 32'h0;
            actAge_reg <= 16'hFFFF;
            refAge_reg <= 16'hFFFF;
            refGap_reg <= 16'h0;
        end else begin
            if (regWrEn && regSel == REG_BANK_BASE) bb_reg <= regWrData;
            if (regWrEn && regSel == REG_BANK_OPTION) bo_reg <= regWrData;
            if (regWrEn && regSel == REG_MODE_TIMING) md_reg <= regWrData;
            if (taken) lat_reg <= reqAddr;
            actAge_reg <= cmd == CMD_ACT ? 16'h1 : actAge_reg + 16'(actAge_reg != 16'hFFFF);
            refAge_reg <= cmd == CMD_REF ? 16'h1 : refAge_reg + 16'(refAge_reg != 16'hFFFF);
            refGap_reg <= !md_reg[MD_REFEN] || cmd == CMD_REF ? 16'h0 : refGap_reg + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    act_lat_a: assert property (taken && !miss |-> ##2 cmd == CMD_ACT)
        else $error("no activate two cycles after a hit");
    miss_err_a: assert property (taken |=> reqError == $past(miss))
        else $error("error pulse disagrees with bank decode");
    act_map_a: assert property (
        cmd == CMD_ACT && ex |-> ma[15:2] == lat_reg[24:11])
        else $error("activate address lines wrong");
    bank_pin_a: assert property (
        cmd == CMD_ACT && ex |-> memPins.bankSel[1:0] == lat_reg[24:23])
        else $error("bank select pins wrong");
    col_map_a: assert property (
        isRw && ex |-> ma[10:2] == lat_reg[10:2] && ma[12])
        else $error("column or precharge line wrong");
    act_space_a: assert property (isRw |-> actAge_reg > 16'(md_reg[11:9]))
        else $error("access too soon after activate");
    ref_recov_a: assert property (
        cmd == CMD_ACT |-> refAge_reg > 16'(md_reg[17:15]))
        else $error("activate too soon after refresh");
    ref_gap_a: assert property (refGap_reg < 16'(2 * REFRESH_COUNT + 64))
        else $error("refresh overdue");

    hit_c: cover property (taken && !miss);
    miss_c: cover property (reqError);
    ref_c: cover property (cmd == CMD_REF);
endmodule

bind sdc_controller sdc_controller_properties #(
    .REFRESH_COUNT(REFRESH_COUNT),
    .REF_WIDTH    (REF_WIDTH)
) props (
    .core_clk, .rst_n, .regSel, .regWrEn, .regRdEn, .regWrData, .regRdData,
    .reqValid, .reqWrite, .reqAddr, .reqReady, .reqError, .reqDone, .memPins
);

// ===== verification/sdc_sdram_model.sv
// SDRAM device model: tracks open banks and counts commands on the pins.
// Assumes auto precharge on every access, so refresh expects all banks closed.
`timescale 1ns/100ps
module sdc_sdram_model
    import sdc_pkg::*;
(
    // Clock and reset
    input  wire logic     core_clk,
    input  wire logic     rst_n,
    // Controller pins
    input  wire sdc_mem_s memPins,
    // Command counts
    output logic [15:0]   actCnt,
    output logic [15:0]   rwCnt,
    output logic [15:0]   refCnt,
    output logic [15:0]   badCnt
);
    logic [7:0] openBank_reg;
    logic [2:0] bk;

    assign bk = memPins.bankSel;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            {actCnt, rwCnt, refCnt, badCnt} <= '0;
            openBank_reg <= 8'h0;
        end else begin
            case (memPins.cmd)
                CMD_ACT: begin
                    badCnt <= badCnt + 16'(openBank_reg[bk]);
                    openBank_reg[bk] <= 1'b1;
                    actCnt <= actCnt + 16'h1;
                end
                CMD_READ, CMD_WRITE: begin
                    // Row only closes itself when the precharge line is high
                    badCnt <= badCnt + 16'(!openBank_reg[bk] || !memPins.addr[12]);
                    openBank_reg[bk] <= 1'b0;
                    rwCnt <= rwCnt + 16'h1;
                end
                CMD_REF: begin
                    badCnt <= badCnt + 16'(openBank_reg != 8'h0);
                    refCnt <= refCnt + 16'h1;
                end
                default: ;
            endcase
        end
    end
endmodule

// ===== verification/sdc_controller_tb.sv
// Self-checking bench: random and corner accesses through sdc_controller.
// Assumes the bound checker and the SDRAM model; refresh period is shortened.
`timescale 1ns/100ps
module sdc_controller_tb
    import sdc_pkg::*;
;
    localparam int REF_CNT = 40;
    logic        core_clk, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
    logic        reqValid = 1'b0, reqWrite = 1'b0, reqReady, reqError, reqDone;
    logic [1:0]  regSel = 2'h0;
    logic [31:0] regWrData = 32'h0, reqAddr = 32'h0, regRdData, seed, ad;
    logic [31:0] cfg [3];
    logic [15:0] actCnt, rwCnt, refCnt, badCnt, refMark;
    sdc_mem_s    memPins;
    int          nMismatch = 0, totalChecks = 0, hits = 0;

    sdc_controller #(.REFRESH_COUNT(REF_CNT)) uut (
        .core_clk, .rst_n, .regSel, .regWrEn, .regRdEn, .regWrData, .regRdData,
        .reqValid, .reqWrite, .reqAddr, .reqReady, .reqError, .reqDone, .memPins
    );
    sdc_sdram_model mem (.core_clk, .rst_n, .memPins, .actCnt, .rwCnt, .refCnt, .badCnt);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic expMiss(input logic [31:0] a, input logic wr);
        return !cfg[0][BB_VALID] || (wr && cfg[0][BB_WPROT])
            || ((a[31:15] ^ cfg[0][31:15]) & cfg[1][31:15]) != 17'h0;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic regWr(input logic [1:0] s, input logic [31:0] d);
        @(negedge core_clk);
        regSel = s;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
        if (s != REG_STATUS) cfg[s] = d;
    endtask

    task automatic regRd(input logic [1:0] s, input logic [31:0] e);
        @(negedge core_clk);
        regSel = s;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        check(regRdData, e);
    endtask

    // Request held until ready, then a bounded wait for error or done
    task automatic access(input logic [31:0] a, input logic wr);
        int n;
        logic err, done, exp;
        exp = expMiss(a, wr);
        @(negedge core_clk);
        reqAddr = a;
        reqWrite = wr;
        reqValid = 1'b1;
        // Ready read once settled; the next rising edge then takes the request
        #1;
        for (n = 0; n < 300 && reqReady !== 1'b1; n++) begin
            @(negedge core_clk);
            #1;
        end
        @(negedge core_clk);
        reqValid = 1'b0;
        err = 1'b0;
        done = 1'b0;
        for (n = 0; n < 100 && !err && !done; n++) begin
            err = reqError;
            done = reqDone;
            if (!err && !done) @(negedge core_clk);
        end
        check({31'h0, err}, {31'h0, exp});
        check({31'h0, done}, {31'h0, !exp});
        if (!exp) hits++;
    endtask

    task automatic closeOut();
        $display("checks %0d, mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h076FA039;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        regWr(REG_STATUS, 32'hFFFF_FFFF);
        regRd(REG_STATUS, 32'h0);
        for (int i = 0; i < 3; i++) begin
            regRd(2'(i), 32'h0);
            seed = lfsr(seed);
            regWr(2'(i), seed);
            regRd(2'(i), seed);
        end
        regWr(REG_BANK_OPTION, 32'hFE00_38C0);
        for (int i = 0; i < 48; i++) begin
            seed = lfsr(seed);
            if (i % 8 == 0) begin
                regWr(REG_MODE_TIMING, {1'b0, seed[31], 12'h054, seed[17:0]});
                regWr(REG_BANK_BASE, {7'h0A, 16'h0, i == 24, 7'h0, i != 16});
                // Settle so no refresh straddles a timing change
                repeat (10) @(negedge core_clk);
            end
            ad = {7'h0A, seed[24:0]};
            if (i % 5 == 1) ad[25] = 1'b1;
            if (i % 8 == 3) ad = {7'h0A, {25{i[3]}}};
            access(ad, seed[30]);
        end
        check(32'(actCnt), 32'(hits));
        check(32'(rwCnt), 32'(hits));
        check(32'(badCnt), 32'h0);
        regWr(REG_MODE_TIMING, 32'h4150_0000);
        refMark = refCnt;
        repeat (5 * REF_CNT) @(negedge core_clk);
        check(32'(refCnt - refMark > 16'h3 && refCnt - refMark < 16'h7), 32'h1);
        access(32'h1400_0100, 1'b1);
        closeOut();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        $display("unexpected at %0t: run did not finish", $time);
        nMismatch++;
        closeOut();
    end
endmodule
